// *** hdl/cfm_fifo_mem.sv ***
`timescale 1ns/1ps
module cfm_fifo_mem #(
  parameter int W  = 65,
  parameter int AW = 4
) (
  // clock
  input  wire logic          aclk,
  input  wire logic          ce,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read side
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_q
);
  logic [W-1:0] mem [2**AW];

  always_ff @(posedge aclk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (ce)
    begin
      rdata_q <= mem[raddr];
    end
  end
endmodule

// *** hdl/cfm_freq_meas.sv ***
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
module cfm_freq_meas #(
  parameter int FIFO_AW = 4
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // measurement pins
  input  wire logic        meas_in,
  input  wire logic        gate_in,
  input  wire logic        sample_in,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // interrupt
  output logic             irq
);
  typedef enum {ST_IDLE, ST_WAIT, ST_RUN} cfm_st_t;

  cfm_pkg::cfm_ctrl_t          ctrl_q;
  logic [31:0]                 divn_q, glen_q, a_q, b_q, p_q, per_q;
  logic [cfm_pkg::IRQ_W-1:0]   istat_q, imask_q;
  logic [2:0]                  ms_q, gs_q, ss_q;
  logic [7:0]                  presc_q;
  logic                        have_q, ok_q, push_q;
  cfm_pkg::cfm_res_t           res_q, head;
  cfm_st_t                     st_q;
  logic [FIFO_AW:0]            wp_q, rp_q;
  logic [cfm_pkg::RES_W-1:0]   mem_rd;
  logic                        aw_have_q, w_have_q;
  logic [7:0]                  awa_q;
  logic [31:0]                 wd_q;
  logic [3:0]                  ws_q;

  function automatic logic [31:0] tb_step(cfm_pkg::cfm_tb_t sel, logic slow_tick);
    case (sel)
      cfm_pkg::TB_80M:  tb_step = 32'(cfm_pkg::TB_FAST_STEP);
      cfm_pkg::TB_20M:  tb_step = 32'h1;
      cfm_pkg::TB_100K: tb_step = {31'h0, slow_tick};
      default:          tb_step = 32'h0;
    endcase
  endfunction

  function automatic logic [31:0] strb_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] s);
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    strb_merge = old;
  endfunction

  // pin synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ms_q <= 3'h0;
      gs_q <= 3'h0;
      ss_q <= 3'h0;
    end
    else if (ce)
    begin
      ms_q <= {ms_q[1:0], meas_in};
      gs_q <= {gs_q[1:0], gate_in};
      ss_q <= {ss_q[1:0], sample_in};
    end
  end

  logic sig_rise, gate_rise, gate_fall, smp_rise, slow_tick;
  logic [31:0] tb_inc, nb;
  assign sig_rise  = ms_q[1] && !ms_q[2];
  assign gate_rise = gs_q[1] && !gs_q[2];
  assign gate_fall = !gs_q[1] && gs_q[2];
  assign smp_rise  = ss_q[1] && !ss_q[2];
  assign slow_tick = (presc_q == 8'(cfm_pkg::TB_SLOW_DIV - 1));
  assign tb_inc    = tb_step(ctrl_q.tb, slow_tick);
  assign nb        = b_q + tb_inc;

  // 100 khz timebase prescaler
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      presc_q <= 8'h00;
    end
    else if (ce)
    begin
      presc_q <= slow_tick ? 8'h00 : presc_q + 8'h01;
    end
  end

  // counter pair a (events) and b (timebase) sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q   <= ST_IDLE;
      a_q    <= 32'h0;
      b_q    <= 32'h0;
      p_q    <= 32'h0;
      per_q  <= 32'h0;
      have_q <= 1'b0;
      ok_q   <= 1'b0;
      push_q <= 1'b0;
      res_q  <= '0;
    end
    else if (ce)
    begin
      push_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          have_q <= 1'b0;
          ok_q   <= 1'b0;
          if (ctrl_q.en)
          begin
            st_q <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          a_q <= 32'h0;
          b_q <= 32'h0;
          p_q <= 32'h0;
          if (!ctrl_q.en)
          begin
            st_q <= ST_IDLE;
          end
          else if ((ctrl_q.mode == cfm_pkg::MODE_SC && smp_rise) ||
                   ((ctrl_q.mode == cfm_pkg::MODE_ONE || ctrl_q.mode == cfm_pkg::MODE_LR) && sig_rise) ||
                   (ctrl_q.mode == cfm_pkg::MODE_HF && (!ctrl_q.ext_gate || gate_rise)))
          begin
            st_q <= ST_RUN;
            // external gate: the rising-edge cycle already lies inside the gate
            if (ctrl_q.mode == cfm_pkg::MODE_HF && ctrl_q.ext_gate)
            begin
              a_q <= {31'h0, sig_rise};
              b_q <= tb_inc;
            end
          end
        end
        ST_RUN:
        begin
          if (!ctrl_q.en)
          begin
            st_q <= ST_IDLE;
          end
          else
          begin
            case (ctrl_q.mode)
              cfm_pkg::MODE_SC:
              begin
                p_q <= sig_rise ? tb_inc : p_q + tb_inc;
                if (smp_rise)
                begin
                  push_q    <= 1'b1;
                  res_q.ovf <= !ok_q;
                  if (!ok_q)
                  begin
                    res_q.evt <= 32'h0;
                    res_q.tb  <= 32'h0;
                  end
                  else if (ctrl_q.frequency_averaging_enable)
                  begin
                    res_q.evt <= a_q;
                    res_q.tb  <= b_q;
                  end
                  else
                  begin
                    res_q.evt <= 32'h1;
                    res_q.tb  <= per_q;
                  end
                  a_q  <= {31'h0, sig_rise};
                  b_q  <= tb_inc;
                  ok_q <= 1'b0;
                end
                else
                begin
                  a_q <= a_q + {31'h0, sig_rise};
                  b_q <= nb;
                end
                if (sig_rise)
                begin
                  have_q <= 1'b1;
                  if (have_q)
                  begin
                    per_q <= p_q;
                    ok_q  <= 1'b1;
                  end
                end
              end
              cfm_pkg::MODE_ONE:
              begin
                if (sig_rise)
                begin
                  push_q <= 1'b1;
                  res_q  <= '{ovf: 1'b0, evt: 32'h1, tb: b_q};
                  b_q    <= tb_inc;
                end
                else
                begin
                  b_q <= nb;
                end
              end
              cfm_pkg::MODE_HF:
              begin
                if (ctrl_q.ext_gate)
                begin
                  // counter a counts events and b the timebase, gate comes from the pin
                  if (gate_fall)
                  begin
                    push_q <= 1'b1;
                    res_q  <= '{ovf: 1'b0, evt: a_q, tb: b_q};
                    st_q   <= ST_WAIT;
                  end
                  else
                  begin
                    a_q <= a_q + {31'h0, sig_rise};
                    b_q <= nb;
                  end
                end
                else if (nb >= glen_q)
                begin
                  push_q <= 1'b1;
                  res_q  <= '{ovf: 1'b0, evt: a_q + {31'h0, sig_rise}, tb: glen_q};
                  a_q    <= 32'h0;
                  b_q    <= 32'h0;
                end
                else
                begin
                  a_q <= a_q + {31'h0, sig_rise};
                  b_q <= nb;
                end
              end
              default:
              begin
                if (sig_rise && (a_q + 32'h1 >= divn_q))
                begin
                  push_q <= 1'b1;
                  res_q  <= '{ovf: 1'b0, evt: a_q + 32'h1, tb: b_q};
                  a_q    <= 32'h0;
                  b_q    <= tb_inc;
                end
                else
                begin
                  a_q <= a_q + {31'h0, sig_rise};
                  b_q <= nb;
                end
              end
            endcase
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // result fifo
  logic empty, full;
  logic [FIFO_AW:0] lvl;
  assign lvl   = wp_q - rp_q;
  assign empty = (wp_q == rp_q);
  assign full  = (wp_q[FIFO_AW] != rp_q[FIFO_AW]) && (wp_q[FIFO_AW-1:0] == rp_q[FIFO_AW-1:0]);
  assign head  = mem_rd;

  cfm_fifo_mem #(
    .W  (cfm_pkg::RES_W),
    .AW (FIFO_AW)
  ) u_mem (
    .aclk    (aclk),
    .ce      (ce),
    .we      (push_q && !full),
    .waddr   (wp_q[FIFO_AW-1:0]),
    .wdata   (res_q),
    .raddr   (rp_q[FIFO_AW-1:0]),
    .rdata_q (mem_rd)
  );

  logic rd_take, pop;
  assign rd_take = arvalid && arready;
  assign pop     = rd_take && (araddr == cfm_pkg::RTB_OFS) && !empty;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else if (ce)
    begin
      if (push_q && !full)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop)
      begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  // axi4-lite write channel
  logic do_wr, wr_hit;
  assign do_wr  = aw_have_q && w_have_q && !bvalid;
  assign wr_hit = (awa_q == cfm_pkg::CTRL_OFS) || (awa_q == cfm_pkg::DIVN_OFS) ||
                  (awa_q == cfm_pkg::GLEN_OFS) || (awa_q == cfm_pkg::IMASK_OFS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awa_q     <= 8'h00;
      wd_q      <= 32'h0;
      ws_q      <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= 2'h0;
      ctrl_q    <= cfm_pkg::CTRL_RST;
      divn_q    <= cfm_pkg::DIVN_RST;
      glen_q    <= cfm_pkg::GLEN_RST;
      imask_q   <= cfm_pkg::IMASK_RST;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_have_q <= 1'b1;
        awready   <= 1'b0;
        awa_q     <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_have_q <= 1'b1;
        wready   <= 1'b0;
        wd_q     <= wdata;
        ws_q     <= wstrb;
      end
      if (do_wr)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_hit ? 2'h0 : 2'h2;
        case (awa_q)
          cfm_pkg::CTRL_OFS:  ctrl_q  <= (cfm_pkg::CTRL_W)'(strb_merge(32'(ctrl_q), wd_q, ws_q));
          cfm_pkg::DIVN_OFS:  divn_q  <= strb_merge(divn_q, wd_q, ws_q);
          cfm_pkg::GLEN_OFS:  glen_q  <= strb_merge(glen_q, wd_q, ws_q);
          cfm_pkg::IMASK_OFS: imask_q <= (cfm_pkg::IRQ_W)'(strb_merge(32'(imask_q), wd_q, ws_q));
          default:            ;
        endcase
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // axi4-lite read channel and interrupt status
  logic [cfm_pkg::IRQ_W-1:0] iset;
  logic                      iclr;
  assign iset = {push_q && full, push_q && res_q.ovf, push_q};
  assign iclr = rd_take && (araddr == cfm_pkg::ISTAT_OFS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= 2'h0;
      istat_q <= '0;
      irq     <= 1'b0;
    end
    else if (ce)
    begin
      istat_q <= (iclr ? '0 : istat_q) | iset;
      irq     <= |(istat_q & imask_q);
      if (rd_take)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= 2'h0;
        case (araddr)
          cfm_pkg::CTRL_OFS:  rdata <= 32'(ctrl_q);
          cfm_pkg::DIVN_OFS:  rdata <= divn_q;
          cfm_pkg::GLEN_OFS:  rdata <= glen_q;
          cfm_pkg::STAT_OFS:  rdata <= {13'h0, head.ovf && !empty, full, empty, 16'(lvl)};
          cfm_pkg::REVT_OFS:  rdata <= head.evt;
          cfm_pkg::RTB_OFS:   rdata <= head.tb;
          cfm_pkg::ISTAT_OFS: rdata <= 32'(istat_q);
          cfm_pkg::IMASK_OFS: rdata <= 32'(imask_q);
          default:
          begin
            rdata <= 32'h0;
            rresp <= 2'h2;
          end
        endcase
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  logic sc_run;
  assign sc_run = (st_q == ST_RUN) && ctrl_q.en && (ctrl_q.mode == cfm_pkg::MODE_SC);
  sequence s_sample_edge;
    sc_run && smp_rise;
  endsequence

  property p_sc_push;
    s_sample_edge |=> push_q ##1 !push_q;
  endproperty
  a_sc_push: assert property (p_sc_push) else $error("sample edge gave no single result");
  property p_sc_ovf;
    s_sample_edge and !ok_q |=> push_q && res_q.ovf && res_q.evt == 32'h0;
  endproperty
  a_sc_ovf: assert property (p_sc_ovf) else $error("missing overflow flag");
  property p_sc_avg;
    s_sample_edge and ok_q && ctrl_q.frequency_averaging_enable |=> res_q.evt == $past(a_q) && res_q.tb == $past(b_q);
  endproperty
  a_sc_avg: assert property (p_sc_avg) else $error("averaged result wrong");
  property p_sc_last;
    s_sample_edge and ok_q && !ctrl_q.frequency_averaging_enable |=> res_q.tb == $past(per_q) && res_q.evt == 32'h1;
  endproperty
  a_sc_last: assert property (p_sc_last) else $error("last period result wrong");
  property p_one;
    (st_q == ST_RUN) && ctrl_q.en && ctrl_q.mode == cfm_pkg::MODE_ONE && sig_rise |=> push_q && res_q.tb == $past(b_q);
  endproperty
  a_one: assert property (p_one) else $error("period result wrong");
  property p_hf;
    push_q && ctrl_q.mode == cfm_pkg::MODE_HF && !ctrl_q.ext_gate |-> res_q.tb == glen_q;
  endproperty
  a_hf: assert property (p_hf) else $error("gate length wrong");
  property p_lr;
    push_q && ctrl_q.mode == cfm_pkg::MODE_LR && divn_q != 32'h0 |-> res_q.evt == divn_q;
  endproperty
  a_lr: assert property (p_lr) else $error("divide-down count wrong");
  property p_slow;
    ctrl_q.tb == cfm_pkg::TB_100K && tb_inc != 32'h0 |=> (tb_inc == 32'h0 || ctrl_q.tb != cfm_pkg::TB_100K) [*8];
  endproperty
  a_slow: assert property (p_slow) else $error("slow timebase too fast");
  property p_fifo;
    push_q && !full && !pop |=> wp_q == $past(wp_q) + 1'b1 && !empty;
  endproperty
  a_fifo: assert property (p_fifo) else $error("result not queued");
endmodule

// *** hdl/cfm_pkg.sv ***
package cfm_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] DIVN_OFS  = 8'h04;
  localparam logic [7:0] GLEN_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS  = 8'h0c;
  localparam logic [7:0] REVT_OFS  = 8'h10;
  localparam logic [7:0] RTB_OFS   = 8'h14;
  localparam logic [7:0] ISTAT_OFS = 8'h18;
  localparam logic [7:0] IMASK_OFS = 8'h1c;

  // control field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_TB_LSB   = 3;
  localparam int CTRL_AVG_BIT  = 5;
  localparam int CTRL_EXTG_BIT = 6;
  localparam int CTRL_W        = 7;

  // status field positions
  localparam int STAT_EMPTY_BIT = 16;
  localparam int STAT_FULL_BIT  = 17;
  localparam int STAT_HOVF_BIT  = 18;

  // interrupt bits
  localparam int IRQ_RES_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;
  localparam int IRQ_OVR_BIT = 2;
  localparam int IRQ_W       = 3;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST  = 7'h20;
  localparam logic [31:0]       DIVN_RST  = 32'h0000_0032;
  localparam logic [31:0]       GLEN_RST  = 32'h0000_4e20;
  localparam logic [IRQ_W-1:0]  IMASK_RST = 3'h0;

  // timebases
  localparam int CLK_HZ      = 20_000_000;
  localparam int TB_FAST_HZ  = 80_000_000;
  localparam int TB_SLOW_HZ  = 100_000;
  localparam int TB_FAST_STEP = TB_FAST_HZ / CLK_HZ;
  localparam int TB_SLOW_DIV  = CLK_HZ / TB_SLOW_HZ;

  typedef enum logic [1:0] {MODE_SC = 2'h0, MODE_ONE = 2'h1, MODE_HF = 2'h2, MODE_LR = 2'h3} cfm_mode_t;
  typedef enum logic [1:0] {TB_80M = 2'h0, TB_20M = 2'h1, TB_100K = 2'h2} cfm_tb_t;

  typedef struct packed {
    logic      ext_gate;
    logic      frequency_averaging_enable;
    cfm_tb_t   tb;
    cfm_mode_t mode;
    logic      en;
  } cfm_ctrl_t;

  typedef struct packed {
    logic        ovf;
    logic [31:0] evt;
    logic [31:0] tb;
  } cfm_res_t;

  localparam int RES_W = 65;

endpackage

// *** testbench/cfm_src.sv ***
`timescale 1ns/1ps
// external source: measured signal, sample clock and gate, all edges just after aclk
module cfm_src (
  // clock
  input  wire logic        aclk,
  // settings
  input  wire logic        meas_on,
  input  wire logic        samp_on,
  input  wire logic [15:0] meas_per,
  input  wire logic [15:0] samp_per,
  // pins
  output logic             meas_in,
  output logic             sample_in,
  output logic             gate_in
);
  int cyc = 0;

  initial
  begin
    meas_in = 1'b0;
    sample_in = 1'b0;
    gate_in = 1'b0;
  end

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    meas_in <= meas_on && ((cyc % meas_per) < (meas_per / 2));
    sample_in <= samp_on && (((cyc + 3) % samp_per) < 2);
    gate_in <= cyc[6];
  end
endmodule

// *** testbench/counter_frequency_measurement_bench.sv ***
`timescale 1ns/1ps
module counter_frequency_measurement_bench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        meas_in;
  logic        gate_in;
  logic        sample_in;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic        irq;
  logic        meas_on = 1'b0;
  logic        samp_on = 1'b0;
  logic [15:0] meas_per = 16'h8;
  logic [15:0] samp_per = 16'h40;
  logic [15:0] rp;
  logic [31:0] got;
  logic [31:0] mm;
  logic [33:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [1:0]  bexp_q[$];
  int          errors = 0;
  int          checks_done = 0;
  integer      seed = 32'ha905f5c5;

  always #25 aclk = ~aclk;

  cfm_freq_meas #(.FIFO_AW(4)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .meas_in(meas_in), .gate_in(gate_in), .sample_in(sample_in),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(irq)
  );

  cfm_src u_src (
    .aclk(aclk), .meas_on(meas_on), .samp_on(samp_on), .meas_per(meas_per),
    .samp_per(samp_per), .meas_in(meas_in), .sample_in(sample_in), .gate_in(gate_in)
  );

  task automatic close_out;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // response watcher: oldest note against each answer
  always @(posedge aclk)
  begin
    if (rvalid === 1'b1 && rready)
    begin
      mm = msk_q.pop_front();
      check("rdata", exp_q.pop_front(), {rresp, rdata & mm});
    end
    if (bvalid === 1'b1 && bready)
      check("bresp", {32'h0, bexp_q.pop_front()}, {32'h0, bresp});
  end

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    bexp_q.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge aclk);
      if (awready === 1'b1 && !ta)
      begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !tw)
      begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    exp_q.push_back({er, e & m});
    msk_q.push_back(m);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    got = rdata;
    rready <= 1'b0;
  endtask

  task automatic pop(input logic [31:0] ee, input logic [31:0] et, input logic [31:0] m);
    axr(cfm_pkg::REVT_OFS, ee, m, 2'h0);
    axr(cfm_pkg::RTB_OFS, et, m, 2'h0);
  endtask

  function automatic logic [31:0] mk(input cfm_pkg::cfm_mode_t md, input cfm_pkg::cfm_tb_t tb, input logic avg);
    cfm_pkg::cfm_ctrl_t c;
    c = '{ext_gate: 1'b0, frequency_averaging_enable: avg, tb: tb, mode: md, en: 1'b1};
    return {25'h0, c};
  endfunction

  // drain, clear flags, run the source, then check two settled entries
  task automatic run(input logic [31:0] ctl, input logic [15:0] mp, input logic [15:0] sp, input logic mon,
                     input logic [31:0] ee, input logic [31:0] et);
    axr(cfm_pkg::STAT_OFS, 32'h0, 32'h0, 2'h0);
    repeat (got[15:0]) pop(32'h0, 32'h0, 32'h0);
    axr(cfm_pkg::ISTAT_OFS, 32'h0, 32'h0, 2'h0);
    repeat (3) @(posedge aclk);
    check("irq idle", 34'h0, {33'h0, irq});
    meas_per <= mp;
    samp_per <= sp;
    meas_on <= mon;
    samp_on <= 1'b1;
    axw(cfm_pkg::CTRL_OFS, ctl, 2'h0);
    do axr(cfm_pkg::STAT_OFS, 32'h0, 32'h0, 2'h0); while (got[15:0] < 16'h3);
    check("irq raised", 34'h1, {33'h0, irq});
    axw(cfm_pkg::CTRL_OFS, ctl & ~32'h1, 2'h0);
    pop(32'h0, 32'h0, 32'h0);
    repeat (2)
    begin
      axr(cfm_pkg::STAT_OFS, {13'h0, et == 32'h0, 18'h0}, 32'h0004_0000, 2'h0);
      pop(ee, et, 32'hffff_ffff);
    end
  endtask

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axr(cfm_pkg::CTRL_OFS, {25'h0, cfm_pkg::CTRL_RST}, 32'hffff_ffff, 2'h0);
    axr(cfm_pkg::DIVN_OFS, cfm_pkg::DIVN_RST, 32'hffff_ffff, 2'h0);
    axr(cfm_pkg::GLEN_OFS, cfm_pkg::GLEN_RST, 32'hffff_ffff, 2'h0);
    axr(cfm_pkg::STAT_OFS, 32'h0001_0000, 32'hffff_ffff, 2'h0);
    axr(cfm_pkg::ISTAT_OFS, 32'h0, 32'hffff_ffff, 2'h0);
    axr(cfm_pkg::IMASK_OFS, 32'h0, 32'hffff_ffff, 2'h0);
    axr(8'h20, 32'h0, 32'hffff_ffff, 2'h2);
    axw(cfm_pkg::STAT_OFS, 32'h1234_5678, 2'h2);
    axw(8'h24, 32'h1, 2'h2);
    axw(cfm_pkg::IMASK_OFS, 32'h3, 2'h0);
    axr(cfm_pkg::IMASK_OFS, 32'h3, 32'h7, 2'h0);
    axw(cfm_pkg::DIVN_OFS, 32'h4, 2'h0);
    wstrb <= 4'h1;
    axw(cfm_pkg::DIVN_OFS, 32'hffff_ff04, 2'h0);
    wstrb <= 4'hf;
    axr(cfm_pkg::DIVN_OFS, 32'h4, 32'hffff_ffff, 2'h0);
    axw(cfm_pkg::GLEN_OFS, 32'h30, 2'h0);
    rp = 16'h8 + 16'($random(seed) & 32'h7);
    run(mk(cfm_pkg::MODE_SC, cfm_pkg::TB_20M, 1'b1), 16'h8, 16'h40, 1'b1, 32'h8, 32'h40);
    run(mk(cfm_pkg::MODE_SC, cfm_pkg::TB_80M, 1'b0), 16'ha, 16'h3c, 1'b1, 32'h1, 32'h28);
    run(mk(cfm_pkg::MODE_ONE, cfm_pkg::TB_20M, 1'b0), rp, 16'h40, 1'b1, 32'h1, {16'h0, rp});
    run(mk(cfm_pkg::MODE_ONE, cfm_pkg::TB_100K, 1'b0), 16'd400, 16'h40, 1'b1, 32'h1, 32'h2);
    run(mk(cfm_pkg::MODE_HF, cfm_pkg::TB_20M, 1'b0), 16'h6, 16'h40, 1'b1, 32'h8, 32'h30);
    run(mk(cfm_pkg::MODE_HF, cfm_pkg::TB_20M, 1'b0) | (32'h1 << cfm_pkg::CTRL_EXTG_BIT),
        16'h8, 16'h40, 1'b1, 32'h8, 32'h40);
    run(mk(cfm_pkg::MODE_LR, cfm_pkg::TB_80M, 1'b0), 16'hc, 16'h40, 1'b1, 32'h4, 32'hc0);
    run(mk(cfm_pkg::MODE_SC, cfm_pkg::TB_20M, 1'b0), 16'h8, 16'h28, 1'b0, 32'h0, 32'h0);
    axw(cfm_pkg::IMASK_OFS, 32'h0, 2'h0);
    repeat (3) @(posedge aclk);
    check("irq masked", 34'h0, {33'h0, irq});
    axr(cfm_pkg::ISTAT_OFS, 32'h2, 32'h2, 2'h0);
    axr(cfm_pkg::ISTAT_OFS, 32'h0, 32'h7, 2'h0);
    close_out;
  end

  // watchdog: the full sequence needs well under ten thousand cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    close_out;
  end
endmodule
